// ===== rtl/os_filter_device.sv
`timescale 1ns/1ns
// device end: oversampling sequencer and averaging filter
module os_filter_device
	import os_filter_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
) (
	input  wire logic                         clk_in,      // 100 mhz clock
	input  wire logic                         rst_n_in,    // sync reset
	os_link_if.device                         link,        // host link
	input  wire logic [CHANNELS*SAMPLE_W-1:0] sample_in,   // raw converter data
	output logic                              sample_strobe_out, // sampling signal
	output logic                              invalid_sel_out    // code 111 seen
);
	typedef enum {ST_IDLE, ST_CONV, ST_DONE} state_e;
	state_e                 state_reg;
	logic [1:0]             start_sync_reg;
	logic                   start_prev_reg;
	logic [SEL_W-1:0]       sel_meta_reg;
	logic [SEL_W-1:0]       sel_sync_reg;
	logic [SEL_W-1:0]       ratio_reg;
	logic [CNT_W-1:0]       timer_reg;
	logic [MAX_SHIFT:0]     left_reg;
	logic                   busy_reg;
	logic [ACC_W-1:0]       acc_reg [CHANNELS];
	logic [CHANNELS*SAMPLE_W-1:0] result_reg;
	logic                   start_rise;
	logic [2:0]             shift;
	logic                   conv_end;

	// both start inputs tied by the host; their AND is what gets watched
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			start_sync_reg <= 2'h0;
			start_prev_reg <= 1'b0;
			sel_meta_reg   <= SEL_NO_OS;
			sel_sync_reg   <= SEL_NO_OS;
		end else begin
			start_sync_reg <= {start_sync_reg[0],
				link.convert_start_first_group &
				link.convert_start_second_group}; // RULE6
			start_prev_reg <= start_sync_reg[1];
			sel_meta_reg   <= link.ratio_select;
			sel_sync_reg   <= sel_meta_reg;
		end
	end
	assign start_rise = start_sync_reg[1] & ~start_prev_reg;
	// invalid code runs as no oversampling
	assign shift    = (ratio_reg == SEL_INVALID) ? 3'h0 : ratio_reg; // RULE3 RULE1
	assign conv_end = (timer_reg == CNT_W'(CONV_CYC - 1));

	// sequencer: first sample on the edge, the rest paced internally
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg         <= ST_IDLE;
			timer_reg         <= '0;
			left_reg          <= '0;
			busy_reg          <= 1'b0;
			sample_strobe_out <= 1'b0;
		end else begin
			sample_strobe_out <= 1'b0;
			unique case (state_reg)
				ST_IDLE: if (start_rise) begin
					state_reg         <= ST_CONV; // RULE4
					busy_reg          <= 1'b1; // RULE7
					timer_reg         <= '0;
					left_reg          <= (MAX_SHIFT+1)'(1) << shift;
					sample_strobe_out <= 1'b1;
				end
				ST_CONV: begin
					timer_reg <= timer_reg + CNT_W'(1);
					if (conv_end) begin
						timer_reg <= '0;
						left_reg  <= left_reg - (MAX_SHIFT+1)'(1);
						if (left_reg == (MAX_SHIFT+1)'(1))
							state_reg <= ST_DONE;
						else
							sample_strobe_out <= 1'b1; // RULE4
					end
				end
				ST_DONE: begin
					busy_reg  <= 1'b0; // RULE7
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ratio latched as busy falls, so a mid-conversion change waits
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ratio_reg       <= SEL_NO_OS;
			invalid_sel_out <= 1'b0;
		end else if (state_reg == ST_DONE) begin
			ratio_reg       <= sel_sync_reg; // RULE2
			invalid_sel_out <= (sel_sync_reg == SEL_INVALID);
		end
	end

	// per channel accumulate, then rounded divide at busy fall
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [ACC_W-1:0] rounded;
			assign rounded = (shift == 3'h0) ? acc_reg[ch] :
				ACC_W'(acc_reg[ch] + (ACC_W'(1) << (shift - 3'h1)));
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					acc_reg[ch] <= '0;
					result_reg[ch*SAMPLE_W +: SAMPLE_W] <= '0;
				end else begin
					if (sample_strobe_out)
						acc_reg[ch] <= ACC_W'(acc_reg[ch] +
							ACC_W'($signed(sample_in[ch*SAMPLE_W +: SAMPLE_W]))); // RULE13
					if (state_reg == ST_DONE) begin
						result_reg[ch*SAMPLE_W +: SAMPLE_W] <=
							SAMPLE_W'($signed(rounded) >>> shift); // RULE5 RULE9
						acc_reg[ch] <= '0;
					end
				end
			end
		end
	endgenerate

	// result stays readable at all times except the update cycle
	assign link.busy   = busy_reg;
	assign link.result = result_reg; // RULE12
endmodule // os_filter_device

// ===== rtl/os_filter_host.sv
`timescale 1ns/1ns
// host end: paces starts for the ratio, captures results
module os_filter_host
	import os_filter_pkg::*;
(
	input  wire logic                         clk_in,       // 100 mhz clock
	input  wire logic                         rst_n_in,     // sync reset
	os_link_if.host                           link,         // device link
	input  wire logic                         go_in,        // request a start
	input  wire logic [SEL_W-1:0]             ratio_in,     // wanted ratio code
	output logic                              ready_out,    // may start again
	output logic                              valid_out,    // result pulse
	output logic [CHANNELS*SAMPLE_W-1:0]      result_out    // captured results
);
	logic [1:0]   busy_sync_reg;
	logic         busy_prev_reg;
	logic [19:0]  gap_reg;
	logic         start_reg;
	logic [SEL_W-1:0] sel_reg;

	// busy from another logic block still passes a synchroniser
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_sync_reg <= 2'h0;
			busy_prev_reg <= 1'b0;
		end else begin
			busy_sync_reg <= {busy_sync_reg[0], link.busy};
			busy_prev_reg <= busy_sync_reg[1];
		end
	end

	// start period doubles per ratio step
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gap_reg   <= '0;
			start_reg <= 1'b0;
			sel_reg   <= SEL_NO_OS;
			ready_out <= 1'b0;
		end else begin
			ready_out <= (gap_reg == '0) && !start_reg;
			if (gap_reg != '0)
				gap_reg <= gap_reg - 20'h1;
			if (start_reg)
				start_reg <= 1'b0;
			else if (go_in && gap_reg == '0) begin
				start_reg <= 1'b1;
				gap_reg   <= 20'(BASE_PERIOD_CYCLES) << sel_reg; // RULE8
			end
			sel_reg <= ratio_in;
		end
	end

	// read once busy is seen low, three cycles after the update edge
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			valid_out  <= 1'b0;
			result_out <= '0;
		end else begin
			valid_out <= busy_prev_reg & ~busy_sync_reg[1]; // RULE10
			if (busy_prev_reg & ~busy_sync_reg[1])
				result_out <= link.result; // RULE11
		end
	end

	assign link.convert_start_first_group  = start_reg; // RULE6
	assign link.convert_start_second_group = start_reg; // RULE6
	assign link.ratio_select               = sel_reg;
endmodule // os_filter_host

// ===== rtl/os_filter_pkg.sv
// Operation
// RULE1: three-bit ratio select, bit two most significant
// RULE2: select latched at busy fall, governs next
// RULE3: codes 000..110 give ratios 1..64, 111 invalid
// RULE4: first sample on start edge, rest internal
// RULE5: average per channel, result 18 bits
// RULE6: host drives both start inputs together
// RULE7: busy high for whole oversampled conversion
// RULE8: host limits start rate per selected ratio
// RULE9: results load into outputs at busy fall
// RULE10: host never reads at busy fall
// RULE11: host reads previous results while busy high; this host reads only once busy is seen low, after the update
// RULE12: reads allowed anytime except busy fall
// RULE13: wide accumulation, divide by ratio with rounding
package os_filter_pkg;
	localparam int          CHANNELS     = 8;
	localparam int          SAMPLE_W     = 18;
	localparam int          SEL_W        = 3;
	localparam int          MAX_SHIFT    = 6;
	localparam int          ACC_W        = SAMPLE_W + MAX_SHIFT;
	localparam logic [2:0]  SEL_INVALID  = 3'h7;
	localparam logic [2:0]  SEL_NO_OS    = 3'h0;
	// time of one conversion and the gap between internal samples
	localparam int          CONV_TIME_NS = 4000;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          CONV_CYCLES  =
		(CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W        = 12;
	// base max start rate in Hz, for the host side; the period doubles per ratio step
	localparam int          BASE_RATE_HZ = 200000;
	localparam int          HOST_CLK_HZ  = 100000000;
	localparam int          BASE_PERIOD_CYCLES = HOST_CLK_HZ / BASE_RATE_HZ;
	typedef logic [SAMPLE_W-1:0] sample_t;
endpackage

// ===== rtl/os_link_if.sv
`timescale 1ns/1ns
// link between host and converter filter end
interface os_link_if;
	import os_filter_pkg::*;
	logic                      convert_start_first_group;
	logic                      convert_start_second_group;
	logic [SEL_W-1:0]          ratio_select;
	logic                      busy;
	logic [CHANNELS*SAMPLE_W-1:0] result;
	modport device (
		input  convert_start_first_group,
		input  convert_start_second_group,
		input  ratio_select,
		output busy,
		output result
	);
	modport host (
		output convert_start_first_group,
		output convert_start_second_group,
		output ratio_select,
		input  busy,
		input  result
	);
endinterface // os_link_if

// ===== verification/os_link_chk.sv
`timescale 1ns/1ns
// watches the link where both ends are design code
module os_link_chk
	import os_filter_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
) (
	input wire logic               clk_in,    // clock
	input wire logic               rst_n_in,  // sync reset
	input wire logic               convert_start_first_group,  // start a
	input wire logic               convert_start_second_group, // start b
	input wire logic [SEL_W-1:0]   ratio_select, // ratio code
	input wire logic               busy,      // conversion running
	input wire logic [CHANNELS*SAMPLE_W-1:0] result // results
);
	logic [15:0] cnt_reg;
	logic [2:0]  sel_reg;
	int          want;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// busy-high cycles; cleared while idle
	always_ff @(posedge clk_in) begin
		cnt_reg <= (rst_n_in && busy) ? cnt_reg + 16'h1 : 16'h0;
	end
	// code in force, taken at each busy fall
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			sel_reg <= 3'h0;
		else if ($fell(busy))
			sel_reg <= ratio_select;
	end
	// invalid code runs unscaled, so it must not stretch busy
	assign want = CONV_CYC * ((sel_reg == 3'h7) ? 1 : (1 << sel_reg)) + 1;
	starts_paired_a:
		assert property (convert_start_first_group ==
			convert_start_second_group) else $error("starts differ");
	busy_length_a:
		assert property ($fell(busy) |-> cnt_reg == want)
		else $error("busy length wrong");
	busy_max_a:
		assert property (cnt_reg <= CONV_CYC * 64 + 1)
		else $error("busy too long");
	res_at_fall_a:
		assert property (!$stable(result) |-> $fell(busy))
		else $error("result changed off busy fall");
	res_hold_a:
		assert property (busy [*2] |-> $stable(result))
		else $error("result moved during busy");
	start_to_busy_a:
		assert property ($rose(convert_start_first_group) && !busy
			|-> ##[1:4] $rose(busy)) else $error("start not taken");
	busy_cause_a:
		assert property ($rose(busy) |-> $past(convert_start_first_group, 2)
			|| $past(convert_start_first_group, 3)
			|| $past(convert_start_first_group, 4)) else $error("busy uncaused");
	busy_gap_a:
		assert property ($fell(busy) |=> !busy) else $error("no idle gap");
endmodule // os_link_chk

// ===== verification/testbench.sv
`timescale 1ns/1ns
// host and device joined, driven through the host user side
module testbench;
	import os_filter_pkg::*;
	localparam int CC = 4;
	localparam int W  = CHANNELS * SAMPLE_W;
	// bit zero of every channel, flipped on alternate samples
	localparam logic [W-1:0] ODD = {CHANNELS{SAMPLE_W'(1)}};
	// tests need about 64k cycles; a hang stops well short of 100k
	localparam int LIMIT = 80000;
	logic         clk_in, rst_n_in, go_in, ready_out, valid_out, invalid_sel_out;
	logic         strobe, phase;
	logic [2:0]   ratio_in, code, prev;
	logic [W-1:0] sample_in, result_out, dev_in, exp_res;
	logic [15:0]  run_len;
	int           mismatches = 0;
	int           tests_run = 0;
	int           cycles = 0;
	int           strobes, wait_len;
	int           pace_exp = 0;
	os_link_if link ();
	os_filter_device #(.CONV_CYC(CC)) u_os_filter_device (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .link(link), .sample_in(dev_in),
		.sample_strobe_out(strobe), .invalid_sel_out(invalid_sel_out));
	// odd samples read base+1, so an even ratio averages to base+0.5
	assign dev_in = phase ? (sample_in ^ ODD) : sample_in;
	os_filter_host u_os_filter_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(link), .go_in(go_in), .ratio_in(ratio_in), .ready_out(ready_out),
		.valid_out(valid_out), .result_out(result_out));
	os_link_chk #(.CONV_CYC(CC)) u_os_link_chk (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .busy(link.busy), .ratio_select(link.ratio_select),
		.convert_start_first_group(link.convert_start_first_group),
		.convert_start_second_group(link.convert_start_second_group),
		.result(link.result));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// watchdog; busy, strobe and not-ready counts since a request
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		run_len <= go_in ? 16'h0 : run_len + 16'(link.busy === 1'b1);
		strobes <= go_in ? 0 : strobes + int'(strobe === 1'b1);
		wait_len <= go_in ? 0 : wait_len + int'(ready_out !== 1'b1);
		phase <= #1 go_in ? 1'b0 : phase ^ (strobe === 1'b1);
		if (cycles == LIMIT) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic check(input string name, input logic [W-1:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one paced conversion; signed per-channel data, every channel negative
	task automatic convert(input logic [2:0] c);
		while (ready_out !== 1'b1) begin
			@(posedge clk_in);
			#1;
		end
		if (pace_exp > 0)
			check("pace", W'(wait_len), W'(pace_exp));
		ratio_in = c;
		// even base per channel, so base+1 is base with bit zero set
		for (int ch = 0; ch < CHANNELS; ch++)
			sample_in[ch*SAMPLE_W +: SAMPLE_W] =
				18'h20000 ^ (18'(ch) * 18'h04322) ^ {14'h0, c, 1'b0};
		go_in = 1'b1;
		@(posedge clk_in);
		#1;
		go_in = 1'b0;
		do begin
			@(posedge clk_in);
			#1;
		end while (valid_out !== 1'b1);
	endtask
	function automatic int ratio(input logic [2:0] c);
		return (c == 3'h7) ? 1 : 1 << c;
	endfunction
	// codes in order then 000 again, so the 128x pacing set at that final start is never waited
	initial begin
		rst_n_in = 1'b0;
		go_in = 1'b0;
		ratio_in = 3'h0;
		sample_in = '0;
		prev = 3'h0;
		repeat (16) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		for (int i = 0; i < 9; i++) begin
			code = 3'(i);
			convert(code);
			exp_res = (ratio(prev) == 1) ? sample_in : (sample_in ^ ODD);
			check("result", result_out, exp_res);
			check("busy", W'(run_len), W'(CC * ratio(prev) + 1));
			check("strobes", W'(strobes), W'(ratio(prev)));
			check("invalid", W'(invalid_sel_out), W'(code == 3'h7));
			@(posedge clk_in);
			#1;
			check("valid", W'(valid_out), W'(0));
			pace_exp = BASE_PERIOD_CYCLES << prev;
			prev = code;
		end
		give_verdict();
	end
endmodule // testbench
